// ### hdl/acr_ctrl.sv
// Purpose : Channel, reference and sequencing control of a 10-bit SAR converter
// Assumes : Comparator output from analog side is synchronous to sys_clk_i
// Notes   : Selections are latched at start so a running conversion is stable
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Ten-bit SAR result into high/low pair
// - All channels share one sample-and-hold
// - Raise done flag on completion
// - Done flag wakes device from sleep
// - Six-bit channel select picks sample source
// - Sources: pins, temperature, DAC, FIXED_VOLTAGE_REF, ground
// - Two-bit positive reference select, four sources
// - Low-voltage variant lacks 4.096V option
// - One bit picks negative pin or ground
// - Enable first, then go in later write
// - Completion clears go, sets flag, updates results
// - Conversion lasts twelve bit periods
// - Three-bit clock select: dividers or RC
module acr_ctrl
    import acr_pkg::*;
#(
    parameter bit LOW_VOLT = 1'b0   // Low-voltage variant strap
) (
    input  wire logic              sys_clk_i,         // System clock, 25 MHz
    input  wire logic              sys_rst_i,         // Async reset, high
    input  wire logic              converter_on_i,    // Converter enable bit
    input  wire logic              go_set_i,          // Write of one to go bit
    input  wire logic              go_clr_i,          // Software abort of go bit
    input  wire logic [CHAN_W-1:0] channel_select_i,  // Channel select field
    input  wire logic [PREF_W-1:0] positive_ref_select_i, // Positive ref field
    input  wire logic              negative_ref_select_i, // Negative ref bit
    input  wire logic [CLKS_W-1:0] conversion_clock_select_i, // Clock select
    input  wire logic              rc_tick_i,         // Dedicated RC clock tick
    input  wire logic              flag_clr_i,        // Software clear of done flag
    input  wire logic              sleep_i,           // Device in sleep
    input  wire logic              cmp_i,             // Comparator: sample above DAC
    output logic                   go_o,              // Go/done bit
    output logic                   conversion_done_flag_o, // Sticky done flag
    output logic                   wake_o,            // Wake request
    output logic [7:0]             result_high_o,     // Result upper byte
    output logic [7:0]             result_low_o,      // Result lower byte
    output logic [CHAN_W-1:0]      mux_sel_o,         // Latched channel
    output logic                   sample_o,          // Sample-and-hold tracking
    output logic [PREF_W-1:0]      pref_sel_o,        // Latched positive ref
    output logic                   nref_sel_o,        // Latched negative ref
    output logic [RES_W-1:0]       dac_code_o         // SAR trial code
);
    acr_state_t       state;
    acr_state_t       next_state;
    logic [CNT_W-1:0] per_cnt;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] trial_bit;
    logic             on_q;
    logic             tick;
    logic             start;
    logic             use_rc;
    logic             abort;
    logic             finish;
    logic             in_sar;
    logic [PREF_W-1:0] pref_eff;

    // ---------------------------------------------------------------
    // Start and abort decode
    // ---------------------------------------------------------------
    // Enable must already be on in the previous cycle: same-write start is dropped
    assign start  = (state == ST_IDLE) && go_set_i && on_q && converter_on_i;
    assign use_rc = (conversion_clock_select_i[1:0] == CLKS_RC_LO);
    // Sleep without RC clock kills the conversion; leaving enable also does
    assign abort  = (state == ST_CONV) && (!converter_on_i || go_clr_i ||
                    (sleep_i && !use_rc));
    assign finish = (state == ST_CONV) && tick && (per_cnt == CONV_PERIODS - 4'h1);
    assign in_sar = (per_cnt >= SAR_FIRST) && (per_cnt <= SAR_LAST);
    // Trial bit walks from MSB down one per period
    assign trial_bit = 10'h200 >> (per_cnt - SAR_FIRST);
    // 4.096V unavailable on low-voltage parts: falls back to 2.048V
    assign pref_eff = (LOW_VOLT && positive_ref_select_i == PREF_FIX4) ?
                      PREF_FIX2 : positive_ref_select_i;

    // ---------------------------------------------------------------
    // Bit-period enable
    // ---------------------------------------------------------------
    acr_tick_div u_div (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (start),
        .sel_i     (conversion_clock_select_i),
        .rc_tick_i (rc_tick_i),
        .tick_o    (tick)
    );

    // ---------------------------------------------------------------
    // State sequencing
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start) next_state = ST_CONV;
            end
            ST_CONV: begin
                if (abort) next_state = ST_IDLE;
                else if (finish) next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            on_q  <= 1'b0;
        end else begin
            state <= next_state;
            on_q  <= converter_on_i;
        end
    end

    // Period counter advances on each conversion clock enable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            per_cnt <= 4'h0;
        end else if (start) begin
            per_cnt <= 4'h0;
        end else if (state == ST_CONV && tick) begin
            per_cnt <= per_cnt + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Selections latched at start for the whole conversion
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mux_sel_o  <= CHAN_GND;
            pref_sel_o <= PREF_PIN;
            nref_sel_o <= NREF_PIN;
        end else if (start) begin
            mux_sel_o  <= channel_select_i;
            pref_sel_o <= pref_eff;
            nref_sel_o <= negative_ref_select_i;
        end
    end

    // Single shared hold: tracks in period 0, holds afterwards
    assign sample_o = (state == ST_CONV) && (per_cnt == 4'h0);

    // ---------------------------------------------------------------
    // Successive approximation register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sar <= 10'h000;
        end else if (start) begin
            sar <= 10'h000;
        end else if (state == ST_CONV && tick && in_sar) begin
            sar <= cmp_i ? (sar | trial_bit) : sar;
        end
    end
    assign dac_code_o = in_sar ? (sar | trial_bit) : sar;

    // ---------------------------------------------------------------
    // Completion: go, flag, results
    // ---------------------------------------------------------------
    // Flag set wins over a same-cycle software clear
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            go_o                   <= 1'b0;
            conversion_done_flag_o <= 1'b0;
            result_high_o          <= 8'h00;
            result_low_o           <= 8'h00;
        end else begin
            if (start) begin
                go_o <= 1'b1;
            end else if (finish || abort) begin
                go_o <= 1'b0;
            end
            if (finish) begin
                conversion_done_flag_o <= 1'b1;
            end else if (flag_clr_i) begin
                conversion_done_flag_o <= 1'b0;
            end
            if (finish) begin
                result_high_o <= {6'h00, sar[9:8]};
                result_low_o  <= sar[7:0];
            end
        end
    end

    // Wake while asleep and flag pending
    assign wake_o = sleep_i && conversion_done_flag_o;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Enables counted apart from the period counter, so a slipped count shows
    logic [CNT_W-1:0] ticks_seen;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ticks_seen <= 4'h0;
        end else if (start) begin
            ticks_seen <= 4'h0;
        end else if (state == ST_CONV && tick) begin
            ticks_seen <= ticks_seen + 4'h1;
        end
    end

    sequence s_start;
        start;
    endsequence
    sequence s_flag_up;
        conversion_done_flag_o && !go_o;
    endsequence

    go_rises_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_start |=> go_o) else $error("go not set after start");
    same_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == ST_IDLE && go_set_i && !on_q) |=> !go_o)
        else $error("start in enabling write");
    done_effects_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        finish |=> s_flag_up) else $error("completion effects missing");
    result_load_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        finish |=> result_low_o == $past(sar[7:0]))
        else $error("result low not updated");
    result_high_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_high_o[7:2] == 6'h00) else $error("result high overflow");
    period_count_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        finish |-> ticks_seen == CONV_PERIODS - 4'h1) else $error("wrong period count");
    sel_stable_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == ST_CONV && !start) |=> $stable(mux_sel_o) && $stable(pref_sel_o))
        else $error("selection moved mid conversion");
    lv_ref_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        LOW_VOLT |-> pref_sel_o != PREF_FIX4) else $error("4.096V on LV");
    flag_wins_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (finish && flag_clr_i) |=> conversion_done_flag_o)
        else $error("clear beat set");
    wake_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (finish && sleep_i) |=> (wake_o || !sleep_i)) else $error("no wake");
    chan_load_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        start |=> mux_sel_o == $past(channel_select_i) && nref_sel_o ==
        $past(negative_ref_select_i)) else $error("channel not latched");
endmodule : acr_ctrl
`default_nettype wire

// ### inc/acr_pkg.sv
// Purpose : Shared constants for the converter channel/reference control
// Assumes : 25 MHz system clock, no register bus (plain ports)
// Notes   : Encodings of reference selects are fixed here
package acr_pkg;
    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int RES_W   = 10;           // Result width
    localparam int CHAN_W  = 6;            // Channel select width
    localparam int PREF_W  = 2;            // Positive reference select width
    localparam int CLKS_W  = 3;            // Conversion clock select width
    localparam int CNT_W   = 4;            // Bit-period counter width
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam logic [CNT_W-1:0] CONV_PERIODS = 4'hc;  // Periods per conversion
    localparam logic [CNT_W-1:0] SAR_FIRST    = 4'h1;  // First decision period
    localparam logic [CNT_W-1:0] SAR_LAST     = 4'ha;  // Last decision period
    localparam int CLK_DIV_W = 6;          // Divider counter width (up to /64)
    // ---------------------------------------------------------------
    // Conversion clock select codes
    // ---------------------------------------------------------------
    localparam logic [CLKS_W-1:0] CLKS_DIV2  = 3'h0;
    localparam logic [CLKS_W-1:0] CLKS_DIV4  = 3'h4;
    localparam logic [CLKS_W-1:0] CLKS_DIV8  = 3'h1;
    localparam logic [CLKS_W-1:0] CLKS_DIV16 = 3'h5;
    localparam logic [CLKS_W-1:0] CLKS_DIV32 = 3'h2;
    localparam logic [CLKS_W-1:0] CLKS_DIV64 = 3'h6;
    localparam logic [1:0]        CLKS_RC_LO = 2'h3;   // Low two bits both one
    // ---------------------------------------------------------------
    // Reference select codes
    // ---------------------------------------------------------------
    localparam logic [PREF_W-1:0] PREF_PIN    = 2'h0;  // External positive pin
    localparam logic [PREF_W-1:0] PREF_SUPPLY = 2'h1;  // Supply voltage
    localparam logic [PREF_W-1:0] PREF_FIX2   = 2'h2;  // Fixed 2.048V
    localparam logic [PREF_W-1:0] PREF_FIX4   = 2'h3;  // Fixed 4.096V
    localparam logic              NREF_PIN    = 1'b0;  // External negative pin
    localparam logic              NREF_GND    = 1'b1;  // Ground
    // ---------------------------------------------------------------
    // Channel codes for internal sources
    // ---------------------------------------------------------------
    localparam logic [CHAN_W-1:0] CHAN_PIN_LAST = 6'h17; // Pins 0..23
    localparam logic [CHAN_W-1:0] CHAN_GND      = 6'h3c;
    localparam logic [CHAN_W-1:0] CHAN_TEMP     = 6'h3d;
    localparam logic [CHAN_W-1:0] CHAN_DAC      = 6'h3e;
    localparam logic [CHAN_W-1:0] CHAN_FVR      = 6'h3f;
    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } acr_state_t;
endpackage : acr_pkg

// ### hdl/acr_tick_div.sv
// Purpose : Conversion clock enable from selectable divider or RC tick
// Assumes : rc_tick_i is synchronous to sys_clk_i
// Notes   : Divider restarts on clear so first period is full length
`timescale 1ns/1ps
`default_nettype none
module acr_tick_div
    import acr_pkg::*;
(
    input  wire logic              sys_clk_i,  // System clock
    input  wire logic              sys_rst_i,  // Async reset, high
    input  wire logic              clear_i,    // Restart divider
    input  wire logic [CLKS_W-1:0] sel_i,      // Clock select
    input  wire logic              rc_tick_i,  // Dedicated RC period pulse
    output logic                   tick_o      // One bit-period enable
);
    logic [CLK_DIV_W-1:0] div_cnt;
    logic [CLK_DIV_W-1:0] div_last;
    logic                 use_rc;

    // ---------------------------------------------------------------
    // Divider terminal count from select
    // ---------------------------------------------------------------
    assign use_rc   = (sel_i[1:0] == CLKS_RC_LO);
    assign div_last = (sel_i == CLKS_DIV2)  ? 6'h01 :
                      (sel_i == CLKS_DIV4)  ? 6'h03 :
                      (sel_i == CLKS_DIV8)  ? 6'h07 :
                      (sel_i == CLKS_DIV16) ? 6'h0f :
                      (sel_i == CLKS_DIV32) ? 6'h1f : 6'h3f;
    assign tick_o   = use_rc ? rc_tick_i : (div_cnt == div_last);

    // Free counter, wraps at terminal count
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= 6'h00;
        end else if (clear_i || use_rc || div_cnt == div_last) begin
            div_cnt <= 6'h00;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end
endmodule : acr_tick_div
`default_nettype wire

// ### tb/acr_analog_model.sv
// Purpose : Analog side model: shared sample-and-hold and comparator
// Assumes : Sample level is synchronous to the system clock
// Notes   : Held level is coded from the latched selects so results are checkable
`timescale 1ns/1ps
`default_nettype none
module acr_analog_model
    import acr_pkg::*;
(
    input  wire logic              sys_clk_i,  // System clock
    input  wire logic              sample_i,   // Track while high
    input  wire logic [CHAN_W-1:0] mux_sel_i,  // Latched channel
    input  wire logic [PREF_W-1:0] pref_sel_i, // Latched positive reference
    input  wire logic              nref_sel_i, // Latched negative reference
    input  wire logic [RES_W-1:0]  dac_code_i, // SAR trial code
    output logic                   cmp_o       // Held level at or above trial
);
    logic [RES_W-1:0] held;
    // One hold for every source; a wrong latch shows up as a wrong result
    always_ff @(posedge sys_clk_i) begin
        if (sample_i) begin
            held <= {mux_sel_i, pref_sel_i, nref_sel_i, 1'b1};
        end
    end
    // Comparator against the trial code
    assign cmp_o = (held >= dac_code_i);
endmodule : acr_analog_model
`default_nettype wire

// ### tb/test_adc_channel_reference_control.sv
// Purpose : Self-checking bench for the converter channel/reference control
// Assumes : 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes   : Random selects come from an LFSR seeded with 62
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_reference_control
    import acr_pkg::*;
;
    logic              sys_clk_i, sys_rst_i, converter_on_i, go_set_i, go_clr_i;
    logic [CHAN_W-1:0] channel_select_i, mux_sel_o;
    logic [PREF_W-1:0] positive_ref_select_i, pref_sel_o, low_pref;
    logic              negative_ref_select_i, nref_sel_o, rc_tick_i, flag_clr_i;
    logic [CLKS_W-1:0] conversion_clock_select_i;
    logic              sleep_i, cmp, go_o, conversion_done_flag_o, wake_o, sample_o;
    logic [7:0]        result_high_o, result_low_o, rnd;
    logic [RES_W-1:0]  dac_code_o;
    int                miscompares, cmp_count, rc_cnt;
    // Normal variant and low-voltage variant share all inputs
    acr_ctrl #(.LOW_VOLT(1'b0)) u_dut (.sys_clk_i, .sys_rst_i, .converter_on_i, .go_set_i,
        .go_clr_i, .channel_select_i, .positive_ref_select_i, .negative_ref_select_i,
        .conversion_clock_select_i, .rc_tick_i, .flag_clr_i, .sleep_i, .cmp_i(cmp), .go_o,
        .conversion_done_flag_o, .wake_o, .result_high_o, .result_low_o, .mux_sel_o,
        .sample_o, .pref_sel_o, .nref_sel_o, .dac_code_o);
    acr_ctrl #(.LOW_VOLT(1'b1)) u_low (.sys_clk_i, .sys_rst_i, .converter_on_i, .go_set_i,
        .go_clr_i, .channel_select_i, .positive_ref_select_i, .negative_ref_select_i,
        .conversion_clock_select_i, .rc_tick_i, .flag_clr_i, .sleep_i, .cmp_i(cmp), .go_o(),
        .conversion_done_flag_o(), .wake_o(), .result_high_o(), .result_low_o(),
        .mux_sel_o(), .sample_o(), .pref_sel_o(low_pref), .nref_sel_o(), .dac_code_o());
    acr_analog_model u_model (.sys_clk_i, .sample_i(sample_o), .mux_sel_i(mux_sel_o),
        .pref_sel_i(pref_sel_o), .nref_sel_i(nref_sel_o), .dac_code_i(dac_code_o),
        .cmp_o(cmp));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    // Divide ratio of a clock select code, zero for the RC source
    function automatic int div_of(input logic [2:0] c);
        case (c)
            3'h0: return 2;
            3'h4: return 4;
            3'h1: return 8;
            3'h5: return 16;
            3'h2: return 32;
            3'h6: return 64;
            default: return 0;
        endcase
    endfunction : div_of
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic start_go();
        go_set_i = 1'b1;
        step();
        go_set_i = 1'b0;
    endtask : start_go
    // Bounded wait for the done flag, counting cycles after the start edge
    task automatic wait_flag(output int n);
        n = 0;
        while (conversion_done_flag_o !== 1'b1 && n < 2000) begin
            step();
            n++;
        end
        chk(16'(conversion_done_flag_o), 16'h0001);
    endtask : wait_flag
    task automatic convert(input logic [2:0] code, input logic [5:0] ch, input bit disturb);
        logic [1:0] pr;
        logic       nr;
        int         n;
        pr = rnd[1:0];
        nr = rnd[2];
        rnd = lfsr_next(rnd);
        channel_select_i = CHAN_GND;
        step();
        conversion_clock_select_i = code;
        channel_select_i = ch;
        positive_ref_select_i = pr;
        negative_ref_select_i = nr;
        repeat (4) step();
        start_go();
        chk(16'(go_o), 16'h0001);
        chk(16'(mux_sel_o), 16'(ch));
        chk(16'(low_pref), 16'((pr == PREF_FIX4) ? PREF_FIX2 : pr));
        if (disturb) begin
            channel_select_i = ~ch;
            positive_ref_select_i = ~pr;
            negative_ref_select_i = ~nr;
        end
        wait_flag(n);
        if (div_of(code) != 0) chk(16'(n), 16'(12 * div_of(code)));
        chk(16'(go_o), 16'h0000);
        chk({result_high_o, result_low_o}, {6'h00, ch, pr, nr, 1'b1});
        flag_clr_i = 1'b1;
        step();
        flag_clr_i = 1'b0;
        chk(16'(conversion_done_flag_o), 16'h0000);
    endtask : convert
    task automatic end_sim();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // ---------------------------------------------------------------
    // Clock, RC tick, watchdog
    // ---------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // RC period of five system clocks, unrelated to the divider
    initial begin
        rc_tick_i = 1'b0;
        rc_cnt = 0;
        forever begin
            step();
            rc_tick_i = (rc_cnt == 0);
            rc_cnt = (rc_cnt + 1) % 5;
        end
    end
    // Run holds one full /64 conversion and faster ones, far below this span
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        miscompares++;
        end_sim();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [15:0] prev;
        int          n;
        {converter_on_i, go_set_i, go_clr_i, flag_clr_i, sleep_i} = 5'h00;
        {channel_select_i, positive_ref_select_i, negative_ref_select_i} = 9'h000;
        conversion_clock_select_i = 3'h0;
        miscompares = 0;
        cmp_count = 0;
        rnd = 8'h3e;
        sys_rst_i = 1'b1;
        repeat (2) step();
        sys_rst_i = 1'b0;
        chk(16'(mux_sel_o), 16'(CHAN_GND));
        chk({result_high_o, result_low_o}, 16'h0000);
        // Enable and go in the same write must be refused
        converter_on_i = 1'b1;
        start_go();
        step();
        chk(16'(go_o), 16'h0000);
        $display("test enable_go done");
        // Every clock code, internal sources and random pins, odd runs disturbed
        for (int i = 0; i < 8; i++) begin
            convert(3'(i), (i % 2 == 0) ? CHAN_GND + 6'(i / 2) : 6'(rnd % 8'd24), i[0]);
        end
        $display("test conversions done");
        // Abort by software, then by sleep on a divided clock
        prev = {result_high_o, result_low_o};
        conversion_clock_select_i = 3'h6;
        start_go();
        repeat (20) step();
        go_clr_i = 1'b1;
        step();
        go_clr_i = 1'b0;
        chk(16'(go_o), 16'h0000);
        step();
        start_go();
        sleep_i = 1'b1;
        repeat (2) step();
        chk(16'(go_o), 16'h0000);
        chk(16'(conversion_done_flag_o), 16'h0000);
        chk({result_high_o, result_low_o}, prev);
        sleep_i = 1'b0;
        // Dropping the enable also ends a running conversion
        start_go();
        converter_on_i = 1'b0;
        step();
        chk(16'(go_o), 16'h0000);
        converter_on_i = 1'b1;
        $display("test aborts done");
        // RC clock keeps converting through sleep and wakes the device
        conversion_clock_select_i = 3'h7;
        step();
        start_go();
        sleep_i = 1'b1;
        // Clear held across completion: the set must still win
        flag_clr_i = 1'b1;
        wait_flag(n);
        chk(16'(wake_o), 16'h0001);
        sleep_i = 1'b0;
        #1;
        chk(16'(wake_o), 16'h0000);
        step();
        chk(16'(conversion_done_flag_o), 16'h0000);
        flag_clr_i = 1'b0;
        $display("test sleep_wake done");
        end_sim();
    end
endmodule : test_adc_channel_reference_control
`default_nettype wire
